// >>> verilog/timer_pwm_pkg.sv
package timer_pwm_pkg;

  localparam int unsigned CHANNELS = 4;

  // register byte addresses
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4001_4000;
  localparam logic [31:0] TIMER_CONTROL_ADDR = 32'h4001_4004;
  localparam logic [31:0] TIMER_COUNT_ADDR = 32'h4001_4008;
  localparam logic [31:0] PRESCALE_TERMINAL_ADDR = 32'h4001_400C;
  localparam logic [31:0] PRESCALE_COUNT_ADDR = 32'h4001_4010;
  localparam logic [31:0] MATCH_ACTION_CONTROL_ADDR = 32'h4001_4014;
  localparam logic [31:0] MATCH_VALUE_0_ADDR = 32'h4001_4018;
  localparam logic [31:0] MATCH_VALUE_1_ADDR = 32'h4001_401C;
  localparam logic [31:0] MATCH_VALUE_2_ADDR = 32'h4001_4020;
  localparam logic [31:0] MATCH_VALUE_3_ADDR = 32'h4001_4024;
  localparam logic [31:0] EXTERNAL_MATCH_CONTROL_ADDR = 32'h4001_403C;
  localparam logic [31:0] PWM_OUTPUT_SELECT_ADDR = 32'h4001_4074;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h4001_4078;

  // field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_HOLD_BIT = 1;
  localparam int unsigned RESET_ON_MATCH_LSB = 0;
  localparam int unsigned STOP_ON_MATCH_LSB = 4;

  // reset values
  localparam logic [3:0] PWM_OUTPUT_SELECT_RST = 4'h0;
  localparam logic [3:0] EXT_MATCH_LEVEL_RST = 4'h0;
  localparam logic [3:0] MATCH_ACTION_RST = 4'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic [31:0] PRESCALE_TERMINAL_RST = 32'h0000_0000;
  localparam logic [31:0] MATCH_VALUE_RST = 32'h0000_0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_IRQ_STATUS,
    SEL_TIMER_CONTROL,
    SEL_TIMER_COUNT,
    SEL_PRESCALE_TERMINAL,
    SEL_PRESCALE_COUNT,
    SEL_MATCH_ACTION,
    SEL_MATCH_VALUE,
    SEL_EXT_MATCH,
    SEL_PWM_SELECT,
    SEL_IRQ_MASK
  } reg_sel_t;

  typedef struct packed {
    logic enable;
    logic hold;
    logic [3:0] pwm_output_select;
    logic [3:0] ext_match_level;
    logic [3:0] reset_on_match;
    logic [3:0] stop_on_match;
    logic [3:0] irq_mask;
    logic [31:0] prescale_terminal;
    logic [3:0][31:0] match_value;
  } timer_regs_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_t;

endpackage

// >>> verilog/match_channel.sv
`timescale 1ns/1ps
module match_channel (
  // clock and control
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic CE,
  // counter view
  input wire logic step,
  input wire logic cyc_start,
  input wire logic [31:0] next_count,
  // configuration
  input wire logic [31:0] match_value,
  input wire logic pwm_sel,
  input wire logic ext_level,
  // results
  output logic arrive,
  output logic pin
);

  logic pin_r;
  logic pin_nxt;

  assign pin = pin_r;

  always_comb begin
    arrive = step && (next_count == match_value);
    pin_nxt = pin_r;
    if (!pwm_sel) begin
      pin_nxt = ext_level;
    end else if (cyc_start) begin
      pin_nxt = (match_value == 32'h0000_0000);
    end else if (arrive) begin
      pin_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pin_r <= 1'b0;
    end else if (CE) begin
      pin_r <= pin_nxt;
    end
  end

  ext_follow_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (!pwm_sel && $stable(ext_level)) |=> (pin == $past(ext_level)))
    else $error("match output does not follow its external level");

  set_high_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (pwm_sel && arrive && !cyc_start) ##1 pwm_sel |-> pin)
    else $error("pwm output not set on match");

  cycle_clear_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (pwm_sel && cyc_start && match_value != 32'h0000_0000) |=> !pin)
    else $error("pwm output not cleared at cycle start");

  zero_hold_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (pwm_sel && cyc_start && match_value == 32'h0000_0000) |=> pin)
    else $error("zero match pwm output not high at cycle start");

endmodule

// >>> verilog/timer_pwm.sv
`timescale 1ns/1ps
// How it works
// - control bits 0..3 pick pwm mode or external-match level per match output
// - up to four outputs run pwm, one match register sets cycle length
// - a match on a non-cycle register drives its pwm output high
// - cycle-length match zeroes the counter and clears high pwm outputs
// - at cycle start all pwm outputs go low unless match value is zero
// - match value above cycle length never matches, output stays low
// - output already high with too-large match value clears at next cycle start
// - match equal to cycle length gives a one-tick positive pulse each cycle
// - zero match value goes high at first return to zero, stays high
// - reset-on-match zeroes counter at end of the matching count period
// - match interrupt rises one clock after counter reaches match value
// - stop-on-match clears enable one clock after match, with the interrupt
module timer_pwm (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic CE,
  // axi4-lite write
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // axi4-lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [31:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // match outputs and interrupt
  output logic [3:0] MATCH_OUTPUT,
  output logic IRQ
);

  function automatic timer_pwm_pkg::reg_sel_t decode(input logic [31:0] a);
    timer_pwm_pkg::reg_sel_t s;
    s = timer_pwm_pkg::SEL_NONE;
    unique case (a)
      timer_pwm_pkg::IRQ_STATUS_ADDR: s = timer_pwm_pkg::SEL_IRQ_STATUS;
      timer_pwm_pkg::TIMER_CONTROL_ADDR: s = timer_pwm_pkg::SEL_TIMER_CONTROL;
      timer_pwm_pkg::TIMER_COUNT_ADDR: s = timer_pwm_pkg::SEL_TIMER_COUNT;
      timer_pwm_pkg::PRESCALE_TERMINAL_ADDR: s = timer_pwm_pkg::SEL_PRESCALE_TERMINAL;
      timer_pwm_pkg::PRESCALE_COUNT_ADDR: s = timer_pwm_pkg::SEL_PRESCALE_COUNT;
      timer_pwm_pkg::MATCH_ACTION_CONTROL_ADDR: s = timer_pwm_pkg::SEL_MATCH_ACTION;
      timer_pwm_pkg::MATCH_VALUE_0_ADDR,
      timer_pwm_pkg::MATCH_VALUE_1_ADDR,
      timer_pwm_pkg::MATCH_VALUE_2_ADDR,
      timer_pwm_pkg::MATCH_VALUE_3_ADDR: s = timer_pwm_pkg::SEL_MATCH_VALUE;
      timer_pwm_pkg::EXTERNAL_MATCH_CONTROL_ADDR: s = timer_pwm_pkg::SEL_EXT_MATCH;
      timer_pwm_pkg::PWM_OUTPUT_SELECT_ADDR: s = timer_pwm_pkg::SEL_PWM_SELECT;
      timer_pwm_pkg::IRQ_MASK_ADDR: s = timer_pwm_pkg::SEL_IRQ_MASK;
      default: s = timer_pwm_pkg::SEL_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = din[8*b +: 8];
      end
    end
    return r;
  endfunction

  // bus state
  timer_pwm_pkg::wr_req_t wr_r, wr_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_go;
  timer_pwm_pkg::reg_sel_t wsel;

  // register state
  timer_pwm_pkg::timer_regs_t regs_r, regs_nxt;
  logic [3:0] status_r, status_nxt;
  logic [3:0] arrive_r, arrive_nxt;

  // counter state
  logic [31:0] tc_r, tc_nxt, pc_r, pc_nxt;
  logic counting, tick, hit_reset, cyc_start;
  logic [3:0] arrive;

  assign AWREADY = !aw_held_r && !bvalid_r;
  assign WREADY = !w_held_r && !bvalid_r;
  assign ARREADY = !rvalid_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign IRQ = |(status_r & regs_r.irq_mask);
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign wsel = decode(wr_r.addr);

  always_comb begin
    wr_nxt = wr_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (AWVALID && AWREADY) begin
      wr_nxt.addr = AWADDR;
      aw_held_nxt = 1'b1;
    end
    if (WVALID && WREADY) begin
      wr_nxt.data = WDATA;
      wr_nxt.strb = WSTRB;
      w_held_nxt = 1'b1;
    end
    if (wr_go) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wsel == timer_pwm_pkg::SEL_NONE) ? timer_pwm_pkg::RESP_SLVERR
                                                    : timer_pwm_pkg::RESP_OKAY;
    end
    if (bvalid_r && BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = timer_pwm_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (decode(ARADDR))
        timer_pwm_pkg::SEL_IRQ_STATUS: rdata_nxt[3:0] = status_r;
        timer_pwm_pkg::SEL_TIMER_CONTROL: begin
          rdata_nxt[timer_pwm_pkg::CTRL_ENABLE_BIT] = regs_r.enable;
          rdata_nxt[timer_pwm_pkg::CTRL_HOLD_BIT] = regs_r.hold;
        end
        timer_pwm_pkg::SEL_TIMER_COUNT: rdata_nxt = tc_r;
        timer_pwm_pkg::SEL_PRESCALE_TERMINAL: rdata_nxt = regs_r.prescale_terminal;
        timer_pwm_pkg::SEL_PRESCALE_COUNT: rdata_nxt = pc_r;
        timer_pwm_pkg::SEL_MATCH_ACTION: begin
          rdata_nxt[timer_pwm_pkg::RESET_ON_MATCH_LSB +: 4] = regs_r.reset_on_match;
          rdata_nxt[timer_pwm_pkg::STOP_ON_MATCH_LSB +: 4] = regs_r.stop_on_match;
        end
        timer_pwm_pkg::SEL_MATCH_VALUE: rdata_nxt = regs_r.match_value[ARADDR[3:2] - 2'h2];
        timer_pwm_pkg::SEL_EXT_MATCH: rdata_nxt[3:0] = regs_r.ext_match_level;
        timer_pwm_pkg::SEL_PWM_SELECT: rdata_nxt[3:0] = regs_r.pwm_output_select;
        timer_pwm_pkg::SEL_IRQ_MASK: rdata_nxt[3:0] = regs_r.irq_mask;
        timer_pwm_pkg::SEL_NONE: rresp_nxt = timer_pwm_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wr_r <= '0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= timer_pwm_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= timer_pwm_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (CE) begin
      wr_r <= wr_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // registers, sticky status and match echo
  always_comb begin
    logic [31:0] cur;
    logic [31:0] nv;
    cur = 32'h0000_0000;
    nv = 32'h0000_0000;
    regs_nxt = regs_r;
    status_nxt = status_r | arrive_r;
    arrive_nxt = arrive;
    if (|(arrive_r & regs_r.stop_on_match)) begin
      regs_nxt.enable = 1'b0;
    end
    if (wr_go) begin
      unique case (wsel)
        timer_pwm_pkg::SEL_IRQ_STATUS: cur[3:0] = status_r;
        timer_pwm_pkg::SEL_TIMER_CONTROL: begin
          cur[timer_pwm_pkg::CTRL_ENABLE_BIT] = regs_r.enable;
          cur[timer_pwm_pkg::CTRL_HOLD_BIT] = regs_r.hold;
        end
        timer_pwm_pkg::SEL_PRESCALE_TERMINAL: cur = regs_r.prescale_terminal;
        timer_pwm_pkg::SEL_MATCH_ACTION: begin
          cur[timer_pwm_pkg::RESET_ON_MATCH_LSB +: 4] = regs_r.reset_on_match;
          cur[timer_pwm_pkg::STOP_ON_MATCH_LSB +: 4] = regs_r.stop_on_match;
        end
        timer_pwm_pkg::SEL_MATCH_VALUE: cur = regs_r.match_value[wr_r.addr[3:2] - 2'h2];
        timer_pwm_pkg::SEL_EXT_MATCH: cur[3:0] = regs_r.ext_match_level;
        timer_pwm_pkg::SEL_PWM_SELECT: cur[3:0] = regs_r.pwm_output_select;
        timer_pwm_pkg::SEL_IRQ_MASK: cur[3:0] = regs_r.irq_mask;
        timer_pwm_pkg::SEL_TIMER_COUNT,
        timer_pwm_pkg::SEL_PRESCALE_COUNT,
        timer_pwm_pkg::SEL_NONE: cur = 32'h0000_0000;
      endcase
      nv = merge(cur, wr_r.data, wr_r.strb);
      unique case (wsel)
        timer_pwm_pkg::SEL_IRQ_STATUS: begin
          // write one clears, a new match wins
          status_nxt = (status_r & ~(nv[3:0] & wr_r.data[3:0])) | arrive_r;
        end
        timer_pwm_pkg::SEL_TIMER_CONTROL: begin
          regs_nxt.enable = nv[timer_pwm_pkg::CTRL_ENABLE_BIT];
          regs_nxt.hold = nv[timer_pwm_pkg::CTRL_HOLD_BIT];
        end
        timer_pwm_pkg::SEL_PRESCALE_TERMINAL: regs_nxt.prescale_terminal = nv;
        timer_pwm_pkg::SEL_MATCH_ACTION: begin
          regs_nxt.reset_on_match = nv[timer_pwm_pkg::RESET_ON_MATCH_LSB +: 4];
          regs_nxt.stop_on_match = nv[timer_pwm_pkg::STOP_ON_MATCH_LSB +: 4];
        end
        timer_pwm_pkg::SEL_MATCH_VALUE: regs_nxt.match_value[wr_r.addr[3:2] - 2'h2] = nv;
        timer_pwm_pkg::SEL_EXT_MATCH: regs_nxt.ext_match_level = nv[3:0];
        timer_pwm_pkg::SEL_PWM_SELECT: regs_nxt.pwm_output_select = nv[3:0];
        timer_pwm_pkg::SEL_IRQ_MASK: regs_nxt.irq_mask = nv[3:0];
        timer_pwm_pkg::SEL_TIMER_COUNT,
        timer_pwm_pkg::SEL_PRESCALE_COUNT,
        timer_pwm_pkg::SEL_NONE: cur = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      regs_r.enable <= 1'b0;
      regs_r.hold <= 1'b0;
      regs_r.pwm_output_select <= timer_pwm_pkg::PWM_OUTPUT_SELECT_RST;
      regs_r.ext_match_level <= timer_pwm_pkg::EXT_MATCH_LEVEL_RST;
      regs_r.reset_on_match <= timer_pwm_pkg::MATCH_ACTION_RST;
      regs_r.stop_on_match <= timer_pwm_pkg::MATCH_ACTION_RST;
      regs_r.irq_mask <= timer_pwm_pkg::IRQ_MASK_RST;
      regs_r.prescale_terminal <= timer_pwm_pkg::PRESCALE_TERMINAL_RST;
      regs_r.match_value <= {4{timer_pwm_pkg::MATCH_VALUE_RST}};
      status_r <= 4'h0;
      arrive_r <= 4'h0;
    end else if (CE) begin
      regs_r <= regs_nxt;
      status_r <= status_nxt;
      arrive_r <= arrive_nxt;
    end
  end

  // prescaler and timer counter
  always_comb begin
    counting = regs_r.enable && !regs_r.hold && !(|(arrive_r & regs_r.stop_on_match));
    tick = counting && (pc_r == regs_r.prescale_terminal);
    hit_reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
      hit_reset = hit_reset || (regs_r.reset_on_match[i] && tc_r == regs_r.match_value[i]);
    end
    cyc_start = tick && hit_reset;
    pc_nxt = pc_r;
    tc_nxt = tc_r;
    if (regs_r.hold) begin
      pc_nxt = 32'h0000_0000;
      tc_nxt = 32'h0000_0000;
    end else if (counting) begin
      pc_nxt = tick ? 32'h0000_0000 : pc_r + 32'h0000_0001;
      if (tick) begin
        tc_nxt = hit_reset ? 32'h0000_0000 : tc_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pc_r <= 32'h0000_0000;
      tc_r <= 32'h0000_0000;
    end else if (CE) begin
      pc_r <= pc_nxt;
      tc_r <= tc_nxt;
    end
  end

  // per-channel compare and output pin
  for (genvar g = 0; g < 4; g++) begin : chan
    match_channel u_ch (
      .CLOCK(CLOCK),
      .SRST(SRST),
      .CE(CE),
      .step(tick),
      .cyc_start(cyc_start),
      .next_count(tc_nxt),
      .match_value(regs_r.match_value[g]),
      .pwm_sel(regs_r.pwm_output_select[g]),
      .ext_level(regs_r.ext_match_level[g]),
      .arrive(arrive[g]),
      .pin(MATCH_OUTPUT[g])
    );
  end

  tc_wrap_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (cyc_start && !regs_r.hold) |=> (tc_r == 32'h0000_0000))
    else $error("counter not zeroed at end of matching period");

  tc_step_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (tick && !hit_reset) |=> (tc_r == $past(tc_r) + 32'h0000_0001))
    else $error("counter did not step on prescaler wrap");

  tc_still_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (!tick && !regs_r.hold) |=> $stable(tc_r))
    else $error("counter moved without prescaler wrap");

  irq_delay_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    arrive[0] |=> (tc_r == regs_r.match_value[0]) ##1 status_r[0])
    else $error("match status not set one clock after counter reached match");

  stop_match_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (arrive[3] && regs_r.stop_on_match[3] && !wr_go) ##1 !wr_go |=> (!regs_r.enable && status_r[3]))
    else $error("stop on match did not clear enable with interrupt");

  pulse_one_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (regs_r.pwm_output_select[1] && regs_r.reset_on_match[3] && arrive[1] && arrive[3]
     && regs_r.prescale_terminal == 32'h0000_0000 && !wr_go)
    |=> MATCH_OUTPUT[1] ##1 !MATCH_OUTPUT[1])
    else $error("equal-to-cycle match not a one tick pulse");

  irq_level_a: assert property (@(posedge CLOCK) disable iff (SRST || !CE)
    (status_r[0] && regs_r.irq_mask[0]) |-> IRQ)
    else $error("unmasked status without interrupt");

endmodule

// >>> sim/pwm_load.sv
`timescale 1ns/1ps
module pwm_load (
  // clock and control
  input wire logic CLOCK,
  input wire logic clr,
  // driven match outputs
  input wire logic [3:0] level,
  // high time seen per output
  output logic [3:0][15:0] high_cnt
);
  // counts high cycles of each output since the last clear
  always_ff @(posedge CLOCK) begin
    for (int c = 0; c < 4; c++) begin
      high_cnt[c] <= clr ? 16'h0000 : high_cnt[c] + 16'(level[c]);
    end
  end
endmodule

// >>> sim/timer_single_edge_pwm_tb.sv
`timescale 1ns/1ps
module timer_single_edge_pwm_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic clr = 1'b0;
  logic ce = 1'b1;
  logic [31:0] awaddr = 32'h00000000;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] araddr = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] mout;
  logic [3:0][15:0] high_cnt;
  int n_fail = 0;
  int tests_run = 0;
  int n, p, m0;
  logic [31:0] d;
  logic [1:0] r;

  always #4 clock = ~clock;

  timer_pwm i_dut (
    .CLOCK(clock), .SRST(srst), .CE(ce),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0),
    .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0),
    .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
    .MATCH_OUTPUT(mout), .IRQ(irq)
  );

  pwm_load i_load (.CLOCK(clock), .clr(clr), .level(mout), .high_cnt(high_cnt));

  task automatic end_sim;
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout;
    n_fail++;
    $display("unexpected at %0t: wait limit reached", $time);
    end_sim();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] dv, input logic [1:0] er);
    int i;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dv;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 50) timeout();
    bready <= 1'b0;
    chk(32'(bresp), 32'(er), "write response");
  endtask

  task automatic w(input logic [31:0] a, input logic [31:0] dv);
    wr(a, dv, timer_pwm_pkg::RESP_OKAY);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] dv, output logic [1:0] rv);
    int i;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 50) timeout();
    dv = rdata;
    rv = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string what);
    logic [31:0] dv;
    logic [1:0] rv;
    rd(a, dv, rv);
    chk(dv, e, what);
    chk(32'(rv), 32'(timer_pwm_pkg::RESP_OKAY), "read response");
  endtask

  // high cycles over k cycle lengths for match value m
  function automatic logic [31:0] hi_exp(int nn, int m, int pp, int k);
    if (m > nn) return 32'h00000000;
    return 32'(k * (nn - m + 1) * (pp + 1));
  endfunction

  task automatic check_run(input int nn, input int pp, input int m);
    int per;
    per = (nn + 1) * (pp + 1);
    repeat (2 * per) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (3 * per) @(posedge clock);
    #1;
    chk(32'(high_cnt[0]), hi_exp(nn, m, pp, 3), "ch0 high time");
    chk(32'(high_cnt[1]), hi_exp(nn, nn, pp, 3), "ch1 pulse time");
    chk(32'(high_cnt[2]), hi_exp(nn, 0, pp, 3), "ch2 zero match");
    chk(32'(high_cnt[3]), 32'(3 * per), "ch3 ext level");
  endtask

  task automatic pwm_trial(input int nn, input int pp, input int m);
    w(timer_pwm_pkg::TIMER_CONTROL_ADDR, 32'h00000002);
    w(timer_pwm_pkg::PRESCALE_TERMINAL_ADDR, 32'(pp));
    w(timer_pwm_pkg::MATCH_VALUE_0_ADDR, 32'(m));
    w(timer_pwm_pkg::MATCH_VALUE_1_ADDR, 32'(nn));
    w(timer_pwm_pkg::MATCH_VALUE_2_ADDR, 32'h00000000);
    w(timer_pwm_pkg::MATCH_VALUE_3_ADDR, 32'(nn));
    w(timer_pwm_pkg::MATCH_ACTION_CONTROL_ADDR, 32'h00000008);
    w(timer_pwm_pkg::EXTERNAL_MATCH_CONTROL_ADDR, 32'h00000008);
    w(timer_pwm_pkg::PWM_OUTPUT_SELECT_ADDR, 32'h00000007);
    w(timer_pwm_pkg::TIMER_CONTROL_ADDR, 32'h00000001);
    check_run(nn, pp, m);
  endtask

  initial begin
    int i;
    void'($urandom(32'h4420AA13));
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    rchk(timer_pwm_pkg::PWM_OUTPUT_SELECT_ADDR, 32'h00000000, "select reset");
    rd(32'h40014100, d, r);
    chk(32'(r), 32'(timer_pwm_pkg::RESP_SLVERR), "unmapped read");
    wr(32'h40014100, 32'h0000000F, timer_pwm_pkg::RESP_SLVERR);
    w(timer_pwm_pkg::PWM_OUTPUT_SELECT_ADDR, 32'h00000000);
    for (i = 0; i < 4; i++) begin
      d = 32'($urandom % 16);
      w(timer_pwm_pkg::EXTERNAL_MATCH_CONTROL_ADDR, d);
      repeat (3) @(posedge clock);
      chk(32'(mout), d, "ext level output");
    end
    for (i = 0; i < 4; i++) begin
      n = 4 + $urandom % 8;
      p = (i == 2) ? 0 : $urandom % 3;
      m0 = (i == 0) ? 1 : (i == 1) ? n + 2 : 1 + $urandom % n;
      pwm_trial(n, p, m0);
    end
    for (i = 0; i < 300 && mout[0] !== 1'b1; i++) @(posedge clock);
    if (i == 300) timeout();
    w(timer_pwm_pkg::MATCH_VALUE_0_ADDR, 32'(n + 5));
    check_run(n, p, n + 5);
    w(timer_pwm_pkg::TIMER_CONTROL_ADDR, 32'h00000002);
    w(timer_pwm_pkg::PRESCALE_TERMINAL_ADDR, 32'h00000000);
    w(timer_pwm_pkg::MATCH_ACTION_CONTROL_ADDR, 32'h00000080);
    w(timer_pwm_pkg::IRQ_MASK_ADDR, 32'h00000008);
    w(timer_pwm_pkg::IRQ_STATUS_ADDR, 32'h0000000F);
    w(timer_pwm_pkg::TIMER_CONTROL_ADDR, 32'h00000001);
    repeat (n + 8) @(posedge clock);
    rchk(timer_pwm_pkg::TIMER_CONTROL_ADDR, 32'h00000000, "enable after stop");
    rchk(timer_pwm_pkg::TIMER_COUNT_ADDR, 32'(n), "count after stop");
    rd(timer_pwm_pkg::IRQ_STATUS_ADDR, d, r);
    chk(d & 32'h00000008, 32'h00000008, "match status");
    chk(32'(irq), 32'h00000001, "irq unmasked");
    w(timer_pwm_pkg::IRQ_MASK_ADDR, 32'h00000000);
    chk(32'(irq), 32'h00000000, "irq masked");
    w(timer_pwm_pkg::IRQ_STATUS_ADDR, 32'h0000000F);
    rchk(timer_pwm_pkg::IRQ_STATUS_ADDR, 32'h00000000, "status cleared");
    w(timer_pwm_pkg::IRQ_MASK_ADDR, 32'h00000008);
    chk(32'(irq), 32'h00000000, "irq after clear");
    w(timer_pwm_pkg::MATCH_ACTION_CONTROL_ADDR, 32'h00000000);
    w(timer_pwm_pkg::TIMER_CONTROL_ADDR, 32'h00000002);
    w(timer_pwm_pkg::TIMER_CONTROL_ADDR, 32'h00000001);
    ce <= 1'b0;
    repeat (20) @(posedge clock);
    ce <= 1'b1;
    rchk(timer_pwm_pkg::TIMER_COUNT_ADDR, 32'h00000002, "count frozen by clock enable");
    end_sim();
  end
endmodule
